// ===== hdl/gang_pin_irq.sv
// ganged output, pin interrupts and stop-mode pin hold
// Operation
// (R1) only the first gang control write after reset is taken
// (R2) bit 0 enables ganging; bits 7:1 add pins to the group
// (R3) bits 7..1 map to b5,b4,b3,b2,c3,c2,c1; enable covers c0
// (R4) ganged pins are outputs copying c0 data, drive and slew
// (R5) ganging enabled forces c0 to output regardless of direction
// (R6) ganging beats digital peripherals; analog beats ganging
// (R7) pin interrupts on a[3:0], b[3:0], also waking from stop3/wait
// (R8) each pin interrupt enabled by its own enable bit
// (R9) per-port mode bit picks edge-only or edge-and-level
// (R10) per-pin polarity picks falling/low or rising/high
// (R11) edges detected on consecutive bus clock samples
// (R12) pin must be seen deasserted before an edge counts
// (R13) edge sets port flag; request while flag and enable set
// (R14) writing ack clears flag in edge-only mode
// (R15) edge-and-level: edge or asserted level sets flag
// (R16) edge-and-level: ack clears only if all enabled inputs idle
// (R17) with pull enabled, polarity 0 pull-up, 1 pull-down
// (R18) software masks, sets polarity, pulls, enables, acks, unmasks
// (R19) stop2 holds pin latches as before stop
// (R20) software checks powerdown flag, restores, then acks
// (R21) stop3 keeps all pin state; usable at once on wake
// (R22) writing powerdown ack clears powerdown recovery flag
// (R23) data read from pin when input, latch when output
// (R24) interrupt pins pass a two-flop synchroniser first
`timescale 1ns/1ps
`default_nettype none
module gang_pin_irq
    import pin_ctrl_pkg::*;
#(
    parameter int PINS = NUM_PINS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // per-pin controls from the port registers
    input wire logic [15:0] portc_data_reg,
    input wire logic [15:0] portc_drive_reg,
    input wire logic [15:0] portc_slew_reg,
    input wire logic [15:0] pin_direction_bit,
    input wire logic [15:0] port_data_latch,
    input wire logic [15:0] periph_en,
    input wire logic [15:0] periph_oe,
    input wire logic [15:0] periph_out,
    input wire logic [15:0] analog_en,
    // pins
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe_n,
    output logic [15:0] pin_drive_hi,
    output logic [15:0] pin_slew,
    output logic [15:0] pin_pull_up,
    output logic [15:0] pin_pull_dn,
    output logic [15:0] port_read_data,
    // power modes
    input wire logic stop2_enter,
    input wire logic stop2_wake,
    // interrupt and wake requests
    output logic irq_a,
    output logic irq_b,
    output logic wake_req
);
    if (PINS != NUM_PINS)
    begin
        $error("gang_pin_irq supports exactly 16 pins");
    end

    // ****************************************
    // apb decode
    // ****************************************
    logic wr_en;
    logic rd_phase;
    assign wr_en = psel && penable && pwrite;
    assign rd_phase = psel && !penable && !pwrite;

    function automatic logic addr_known(input logic [7:0] a);
        return a == OFF_GANG_CTRL || a == OFF_IRQ_SC_A ||
            a == OFF_IRQ_SC_B || a == OFF_IRQ_EN || a == OFF_IRQ_POL ||
            a == OFF_PULL_EN || a == OFF_PPD || a == OFF_PIN_STATE;
    endfunction

    // ****************************************
    // gang control, write once
    // ****************************************
    logic [7:0] gang_ctrl_reg_q;
    logic gang_locked_q;
    logic gang_enable;
    logic [15:0] gang_pin_select;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            gang_ctrl_reg_q <= GANG_RST;
            gang_locked_q <= 1'b0;
        end
        else if (wr_en && paddr == OFF_GANG_CTRL && !gang_locked_q) // R1
        begin
            gang_ctrl_reg_q <= pwdata[7:0]; // R2
            gang_locked_q <= 1'b1; // R1
        end
    end
    assign gang_enable = gang_ctrl_reg_q[0]; // R2
    assign gang_pin_select = gang_enable ?
        gang_map(gang_ctrl_reg_q) : 16'h0000; // R3

    // ****************************************
    // pin interrupt control registers
    // ****************************************
    logic [7:0] pin_irq_enable_reg_q;
    logic [7:0] pin_irq_polarity_reg_q;
    logic [7:0] pull_enable_reg_q;
    logic [1:0] pin_irq_detect_mode_q;
    logic [1:0] pin_irq_int_enable_q;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_irq_enable_reg_q <= BYTE_RST;
            pin_irq_polarity_reg_q <= BYTE_RST;
            pull_enable_reg_q <= BYTE_RST;
            pin_irq_detect_mode_q <= 2'h0;
            pin_irq_int_enable_q <= 2'h0;
        end
        else if (wr_en)
        begin
            if (paddr == OFF_IRQ_EN)
                pin_irq_enable_reg_q <= pwdata[7:0]; // R8
            if (paddr == OFF_IRQ_POL)
                pin_irq_polarity_reg_q <= pwdata[7:0]; // R10
            if (paddr == OFF_PULL_EN)
                pull_enable_reg_q <= pwdata[7:0];
            if (paddr == OFF_IRQ_SC_A)
            begin
                pin_irq_detect_mode_q[0] <= pwdata[SC_MODE_BIT]; // R9
                pin_irq_int_enable_q[0] <= pwdata[SC_IE_BIT];
            end
            if (paddr == OFF_IRQ_SC_B)
            begin
                pin_irq_detect_mode_q[1] <= pwdata[SC_MODE_BIT]; // R9
                pin_irq_int_enable_q[1] <= pwdata[SC_IE_BIT];
            end
        end
    end

    // ****************************************
    // synchroniser and edge detection
    // ****************************************
    logic [7:0] irq_pins;
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] prev_q;
    logic [7:0] armed_q;
    logic [7:0] asserted;
    logic [7:0] edge_hit;
    assign irq_pins = {pin_in[7:4], pin_in[3:0]}; // R7
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            prev_q <= 8'h00;
        end
        else
        begin
            sync1_q <= irq_pins; // R24
            sync2_q <= sync1_q; // R24
            prev_q <= sync2_q; // R11
        end
    end
    // asserted level: high when polarity 1, low when 0
    assign asserted = ~(sync2_q ^ pin_irq_polarity_reg_q); // R10
    always_ff @(posedge clk)
    begin
        if (rst)
            armed_q <= 8'h00;
        else
            armed_q <= pin_irq_enable_reg_q &
                (armed_q | ~asserted); // R12
    end
    // previous sample deasserted, current asserted
    assign edge_hit = pin_irq_enable_reg_q & armed_q & asserted &
        (prev_q ^ sync2_q); // R11

    // ****************************************
    // port flags
    // ****************************************
    logic [1:0] pin_irq_flag_q;
    logic [1:0] set_ev;
    logic [1:0] lvl_active;
    logic [1:0] ack_wr;
    always_comb
    begin
        lvl_active[0] = |(pin_irq_enable_reg_q[3:0] & asserted[3:0]);
        lvl_active[1] = |(pin_irq_enable_reg_q[7:4] & asserted[7:4]);
        set_ev[0] = |edge_hit[3:0] ||
            (pin_irq_detect_mode_q[0] && lvl_active[0]); // R13 R15
        set_ev[1] = |edge_hit[7:4] ||
            (pin_irq_detect_mode_q[1] && lvl_active[1]); // R13 R15
        ack_wr[0] = wr_en && paddr == OFF_IRQ_SC_A && pwdata[SC_ACK_BIT];
        ack_wr[1] = wr_en && paddr == OFF_IRQ_SC_B && pwdata[SC_ACK_BIT];
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            pin_irq_flag_q <= 2'h0;
        else
        begin
            for (int p = 0; p < 2; p++)
            begin
                if (set_ev[p])
                    pin_irq_flag_q[p] <= 1'b1; // R13
                else if (ack_wr[p] &&
                    !(pin_irq_detect_mode_q[p] && lvl_active[p]))
                    pin_irq_flag_q[p] <= 1'b0; // R14 R16
            end
        end
    end

    // ****************************************
    // partial powerdown and pin hold
    // ****************************************
    logic partial_powerdown_flag_q;
    logic hold_q;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            partial_powerdown_flag_q <= 1'b0;
            hold_q <= 1'b0;
        end
        else
        begin
            if (stop2_enter)
                hold_q <= 1'b1; // R19
            if (stop2_wake)
                partial_powerdown_flag_q <= 1'b1;
            else if (wr_en && paddr == OFF_PPD && pwdata[PPD_ACK_BIT])
            begin
                partial_powerdown_flag_q <= 1'b0; // R22
                hold_q <= 1'b0; // R20
            end
        end
    end

    // ****************************************
    // pin muxing
    // ****************************************
    logic [15:0] oe_d;
    logic [15:0] out_d;
    logic [15:0] ds_d;
    logic [15:0] sl_d;
    logic [15:0] pu_d;
    logic [15:0] pd_d;
    logic [15:0] pull_on;
    logic [15:0] gang_all;
    always_comb
    begin
        gang_all = gang_pin_select;
        pull_on = {8'h00, pull_enable_reg_q};
        for (int i = 0; i < 16; i++)
        begin
            oe_d[i] = periph_en[i] ? periph_oe[i] : pin_direction_bit[i];
            out_d[i] = periph_en[i] ? periph_out[i] : port_data_latch[i];
            ds_d[i] = portc_drive_reg[i];
            sl_d[i] = portc_slew_reg[i];
            if (gang_all[i]) // R4 R5 R6
            begin
                oe_d[i] = 1'b1;
                out_d[i] = portc_data_reg[PIN_C0];
                ds_d[i] = portc_drive_reg[PIN_C0];
                sl_d[i] = portc_slew_reg[PIN_C0];
            end
            if (analog_en[i]) // R6
            begin
                oe_d[i] = 1'b0;
                out_d[i] = 1'b0;
            end
            pu_d[i] = 1'b0;
            pd_d[i] = 1'b0;
            if (i < 8 && pull_on[i] && !oe_d[i] && !analog_en[i])
            begin
                pu_d[i] = !pin_irq_polarity_reg_q[i[2:0]]; // R17
                pd_d[i] = pin_irq_polarity_reg_q[i[2:0]]; // R17
            end
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_out <= 16'h0000;
            pin_oe_n <= 16'hffff;
            pin_drive_hi <= 16'h0000;
            pin_slew <= 16'h0000;
            pin_pull_up <= 16'h0000;
            pin_pull_dn <= 16'h0000;
            port_read_data <= 16'h0000;
        end
        else if (!hold_q) // R19 R21
        begin
            pin_out <= out_d;
            pin_oe_n <= ~oe_d;
            pin_drive_hi <= ds_d;
            pin_slew <= sl_d;
            pin_pull_up <= pu_d;
            pin_pull_dn <= pd_d;
            port_read_data <= (pin_direction_bit & port_data_latch) |
                (~pin_direction_bit & pin_in & ~analog_en); // R23
        end
    end

    // ****************************************
    // requests and apb answer
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_a <= 1'b0;
            irq_b <= 1'b0;
            wake_req <= 1'b0;
        end
        else
        begin
            irq_a <= pin_irq_flag_q[0] && pin_irq_int_enable_q[0]; // R13
            irq_b <= pin_irq_flag_q[1] && pin_irq_int_enable_q[1]; // R13
            wake_req <= |(pin_irq_flag_q & pin_irq_int_enable_q); // R7
        end
    end

    logic [31:0] rd_d;
    always_comb
    begin
        rd_d = 32'h0000_0000;
        unique case (paddr)
            OFF_GANG_CTRL: rd_d[7:0] = gang_ctrl_reg_q;
            OFF_IRQ_SC_A: rd_d[3:0] = {pin_irq_flag_q[0], 1'b0,
                pin_irq_int_enable_q[0], pin_irq_detect_mode_q[0]};
            OFF_IRQ_SC_B: rd_d[3:0] = {pin_irq_flag_q[1], 1'b0,
                pin_irq_int_enable_q[1], pin_irq_detect_mode_q[1]};
            OFF_IRQ_EN: rd_d[7:0] = pin_irq_enable_reg_q;
            OFF_IRQ_POL: rd_d[7:0] = pin_irq_polarity_reg_q;
            OFF_PULL_EN: rd_d[7:0] = pull_enable_reg_q;
            OFF_PPD: rd_d[PPD_FLAG_BIT] = partial_powerdown_flag_q;
            OFF_PIN_STATE: rd_d[15:0] = port_read_data;
            default: rd_d = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_known(paddr);
            if (rd_phase)
                prdata <= rd_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_gang_write_once: assert property (@(posedge clk) disable iff (rst)
        gang_locked_q |=> $stable(gang_ctrl_reg_q)) // R1
        else $error("gang control changed after first write");
    chk_ack_edge_clear: assert property (@(posedge clk) disable iff (rst)
        ack_wr[0] && !set_ev[0] && !pin_irq_detect_mode_q[0]
        |=> !pin_irq_flag_q[0]) // R14
        else $error("ack did not clear port a flag");
    chk_level_holds_flag: assert property (@(posedge clk) disable iff (rst)
        ack_wr[1] && pin_irq_detect_mode_q[1] && lvl_active[1]
        |=> pin_irq_flag_q[1]) // R16
        else $error("flag cleared while level asserted");
    chk_irq_follows_flag: assert property (@(posedge clk) disable iff (rst)
        pin_irq_flag_q[1] && pin_irq_int_enable_q[1] |=> irq_b) // R13
        else $error("missing port b request");
    chk_ppd_ack_clear: assert property (@(posedge clk) disable iff (rst)
        wr_en && paddr == OFF_PPD && pwdata[PPD_ACK_BIT] && !stop2_wake
        |=> !partial_powerdown_flag_q) // R22
        else $error("powerdown flag not cleared");
    chk_c0_forced_out: assert property (@(posedge clk) disable iff (rst)
        gang_enable && !analog_en[PIN_C0] && !hold_q
        |=> !pin_oe_n[PIN_C0]) // R5
        else $error("c0 not driven while ganged");
    chk_hold_freezes: assert property (@(posedge clk) disable iff (rst)
        hold_q && $past(hold_q) |-> $stable(pin_out) && $stable(pin_oe_n)) // R19
        else $error("pins moved during stop2 hold");
    chk_edge_sets_flag: assert property (@(posedge clk) disable iff (rst)
        |edge_hit[7:4] |=> pin_irq_flag_q[1]) // R13
        else $error("edge lost on port b");
endmodule
`default_nettype wire

// ===== hdl/pin_ctrl_pkg.sv
// constants for the ganged output and pin interrupt block
package pin_ctrl_pkg;
    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFF_GANG_CTRL = 8'h00;
    localparam logic [7:0] OFF_IRQ_SC_A = 8'h04;
    localparam logic [7:0] OFF_IRQ_SC_B = 8'h08;
    localparam logic [7:0] OFF_IRQ_EN = 8'h0c;
    localparam logic [7:0] OFF_IRQ_POL = 8'h10;
    localparam logic [7:0] OFF_PULL_EN = 8'h14;
    localparam logic [7:0] OFF_PPD = 8'h18;
    localparam logic [7:0] OFF_PIN_STATE = 8'h1c;
    // ****************************************
    // status and control fields
    // ****************************************
    localparam int SC_MODE_BIT = 0;
    localparam int SC_IE_BIT = 1;
    localparam int SC_ACK_BIT = 2;
    localparam int SC_FLAG_BIT = 3;
    localparam int PPD_FLAG_BIT = 3;
    localparam int PPD_ACK_BIT = 2;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] GANG_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // ****************************************
    // pin positions in the 16-bit pin vector
    // a[3:0]=0..3, b[7:0]=4..11, c[3:0]=12..15
    // ****************************************
    localparam int PIN_C0 = 12;
    localparam int NUM_PINS = 16;
    function automatic logic [15:0] gang_map(input logic [7:0] g);
        logic [15:0] m;
        m = 16'h0000;
        m[12] = g[0];
        m[13] = g[1];
        m[14] = g[2];
        m[15] = g[3];
        m[6] = g[4];
        m[7] = g[5];
        m[8] = g[6];
        m[9] = g[7];
        return m;
    endfunction
endpackage

// ===== test/pin_partner.sv
// external pin model: outside drivers, pull resistors, floating pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner
(
    // clock
    input wire logic clk,
    // device side of the pins
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe_n,
    input wire logic [15:0] pin_pull_up,
    input wire logic [15:0] pin_pull_dn,
    // outside drivers
    input wire logic [15:0] ext_val,
    input wire logic [15:0] ext_en,
    // resolved pin level
    output logic [15:0] pin_in
);
    logic [15:0] last_q = 16'h0000;
    always @(posedge clk)
    begin
        last_q <= pin_in;
    end
    // a floating pin toggles so no stale level survives
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pin_pull_up[i])
                pin_in[i] = 1'b1;
            else if (pin_pull_dn[i])
                pin_in[i] = 1'b0;
            else
                pin_in[i] = ~last_q[i];
        end
    end
endmodule
`default_nettype wire

// ===== test/test_ganged_output_pin_interrupt.sv
// self-checking bench for the ganged output and pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_ganged_output_pin_interrupt;
    import pin_ctrl_pkg::*;
    localparam logic [31:0] MOD = 32'h1 << SC_MODE_BIT;
    localparam logic [31:0] IE = 32'h1 << SC_IE_BIT;
    localparam logic [31:0] ACK = 32'h1 << SC_ACK_BIT;
    localparam logic [31:0] FLG = 32'h1 << SC_FLAG_BIT;
    localparam logic [31:0] PFLG = 32'h1 << PPD_FLAG_BIT;
    localparam logic [31:0] PACK = 32'h1 << PPD_ACK_BIT;
    logic clk = 1'b0, rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, m_n, rnd = 32'h20;
    logic pready, pslverr, irq_a, irq_b, wake_req;
    logic [15:0] c_data = 16'h0, c_drive = 16'h0, c_slew = 16'h0;
    logic [15:0] dir = 16'h0, latch = 16'h0, p_en = 16'h0;
    logic [15:0] p_oe = 16'h0, p_out = 16'h0, a_en = 16'h0;
    logic [15:0] ext_val = 16'h0, ext_en = 16'h0003;
    logic [15:0] pin_in, pin_out, pin_oe_n, drv, slw, pu, pd, rdd;
    logic stop2_enter = 1'b0, stop2_wake = 1'b0;
    logic [32:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [32:0] e_n;
    logic [1:0] ex;
    int num_errors = 0;
    int n_compared = 0;

    always #2 clk = ~clk;

    gang_pin_irq dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .portc_data_reg(c_data), .portc_drive_reg(c_drive),
        .portc_slew_reg(c_slew), .pin_direction_bit(dir),
        .port_data_latch(latch), .periph_en(p_en), .periph_oe(p_oe),
        .periph_out(p_out), .analog_en(a_en), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_drive_hi(drv),
        .pin_slew(slw), .pin_pull_up(pu), .pin_pull_dn(pd),
        .port_read_data(rdd), .stop2_enter(stop2_enter),
        .stop2_wake(stop2_wake), .irq_a(irq_a), .irq_b(irq_b),
        .wake_req(wake_req)
    );

    pin_partner pins (
        .clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pull_up(pu), .pin_pull_dn(pd), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    // one apb transfer; the expected answer is noted for the monitor
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e,
                       input logic [31:0] m);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        apb(1'b0, a, 32'h0, {1'b0, e}, m);
    endtask

    task automatic wait_irq(input logic port_b, input logic e);
        int n;
        n = 0;
        while ((port_b ? irq_b : irq_a) !== e && n < 12)
        begin
            @(posedge clk);
            n++;
        end
        chk("irq", {15'h0, e}, {15'h0, port_b ? irq_b : irq_a});
        chk("wake", {15'h0, e}, {15'h0, wake_req});
    endtask

    task automatic end_sim;
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************
    // monitor of completed apb transfers
    // ****************************************
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
        begin
            e_n = exp_q.pop_front();
            m_n = msk_q.pop_front();
            n_compared++;
            if ({pslverr, prdata & m_n} !== e_n)
            begin
                num_errors++;
                $display("MISMATCH apb exp %h got %h", e_n,
                         {pslverr, prdata & m_n});
            end
        end
    end

    initial
    begin
        #40000;
        num_errors++;
        $display("MISMATCH watchdog exp done got hang");
        end_sim;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        chk("oe_n", 16'hffff, pin_oe_n);
        rd(OFF_GANG_CTRL, {24'h0, GANG_RST}, 32'hff);
        apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0}, 32'h0);
        // pin interrupt bring-up in the safe order
        wr(OFF_IRQ_SC_A, 32'h0);
        wr(OFF_IRQ_SC_B, MOD);
        wr(OFF_IRQ_POL, 32'h10);
        wr(OFF_PULL_EN, 32'h11);
        repeat (3) @(posedge clk);
        chk("pull_up", 16'h0001, pu & 16'h0011);
        chk("pull_dn", 16'h0010, pd & 16'h0011);
        wr(OFF_IRQ_EN, 32'h11);
        repeat (8) @(posedge clk);
        rd(OFF_IRQ_SC_A, 32'h0, FLG);
        wr(OFF_IRQ_SC_A, ACK | IE);
        wr(OFF_IRQ_SC_B, ACK | IE | MOD);
        ext_en <= 16'h0002;
        repeat (6) @(posedge clk);
        chk("irq_a", 16'h0, {15'h0, irq_a});
        ext_en <= 16'h0003;
        wait_irq(1'b0, 1'b1);
        rd(OFF_IRQ_SC_A, FLG, FLG);
        wr(OFF_IRQ_SC_A, ACK | IE);
        rd(OFF_IRQ_SC_A, 32'h0, FLG);
        chk("irq_a", 16'h0, {15'h0, irq_a});
        ext_val <= 16'h0002;
        repeat (4) @(posedge clk);
        ext_val <= 16'h0000;
        repeat (8) @(posedge clk);
        chk("irq_a", 16'h0, {15'h0, irq_a});
        // port b: edge and level, rising or high
        ext_en <= 16'h0013;
        ext_val <= 16'h0010;
        wait_irq(1'b1, 1'b1);
        wr(OFF_IRQ_SC_B, ACK | IE | MOD);
        rd(OFF_IRQ_SC_B, FLG, FLG);
        ext_en <= 16'h0003;
        repeat (6) @(posedge clk);
        wr(OFF_IRQ_SC_B, ACK | IE | MOD);
        rd(OFF_IRQ_SC_B, 32'h0, FLG);
        chk("irq_b", 16'h0, {15'h0, irq_b});
        // flag without request while masked
        wr(OFF_IRQ_SC_A, 32'h0);
        ext_en <= 16'h0002;
        repeat (6) @(posedge clk);
        ext_en <= 16'h0003;
        repeat (8) @(posedge clk);
        chk("irq_a", 16'h0, {15'h0, irq_a});
        chk("wake", 16'h0, {15'h0, wake_req});
        rd(OFF_IRQ_SC_A, FLG, FLG);
        // ganging with a peripheral and an analog pin in the group
        a_en <= 16'h0200;
        p_en <= 16'h0040;
        p_oe <= 16'h0040;
        wr(OFF_GANG_CTRL, 32'h93);
        wr(OFF_GANG_CTRL, 32'h00);
        rd(OFF_GANG_CTRL, 32'h93, 32'hff);
        for (int k = 0; k < 4; k++)
        begin
            rnd = lfsr(rnd);
            c_data[12] <= rnd[0];
            c_slew[12] <= rnd[1];
            c_drive[12] <= rnd[2];
            dir[11:10] <= rnd[4:3];
            latch <= rnd[31:16];
            ext_val[11:10] <= rnd[6:5];
            ext_en[11:10] <= ~rnd[4:3];
            ex = (rnd[4:3] & rnd[27:26]) | (~rnd[4:3] & rnd[6:5]);
            repeat (5) @(posedge clk);
            chk("oe_n", 16'h0280, pin_oe_n & 16'h32c0);
            chk("out", {16{rnd[0]}} & 16'h3040, pin_out & 16'h3040);
            chk("drive", {16{rnd[2]}} & 16'h3040, drv & 16'h3040);
            chk("slew", {16{rnd[1]}} & 16'h3040, slw & 16'h3040);
            chk("read", {4'h0, ex, 10'h0}, rdd & 16'h0e00);
        end
        // stop2 holds the pins until the powerdown ack
        c_data[12] <= 1'b1;
        repeat (5) @(posedge clk);
        stop2_enter <= 1'b1;
        @(posedge clk);
        stop2_enter <= 1'b0;
        c_data[12] <= 1'b0;
        repeat (5) @(posedge clk);
        chk("held", 16'h1000, pin_out & 16'h1000);
        stop2_wake <= 1'b1;
        @(posedge clk);
        stop2_wake <= 1'b0;
        rd(OFF_PPD, PFLG, PFLG);
        wr(OFF_PPD, PACK);
        rd(OFF_PPD, 32'h0, PFLG);
        repeat (5) @(posedge clk);
        chk("released", 16'h0, pin_out & 16'h1000);
        end_sim;
    end
endmodule
`default_nettype wire
